// [hw/sws_pkg.sv]
package sws_pkg;

    // register byte addresses
    localparam logic [4:0] SWS_SYNTH_LATCH_ADDR = 5'h00;
    localparam logic [4:0] SWS_XMIT_LATCH_ADDR = 5'h04;
    localparam logic [4:0] SWS_MEM_IF_ADDR = 5'h08;
    localparam logic [4:0] SWS_SERVICE_ADDR = 5'h0c;
    localparam logic [4:0] SWS_STATUS_ADDR = 5'h10;

    // synth latch fields
    localparam int SWS_SYN_SCLK_BIT = 0;
    localparam int SWS_SYN_SDATA_BIT = 1;
    localparam int SWS_SYN_TX_LOAD_N_BIT = 2;
    localparam int SWS_SYN_RX_LOAD_N_BIT = 3;
    // transmit latch fields
    localparam int SWS_XM_KEY_BIT = 0;
    localparam int SWS_XM_CARRIER_BIT = 1;
    // memory interface fields
    localparam int SWS_MEM_SCL_BIT = 0;
    localparam int SWS_MEM_SDA_LOW_BIT = 1;
    // status fields
    localparam int SWS_ST_TX_LOCK_BIT = 0;
    localparam int SWS_ST_RX_LOCK_BIT = 1;
    localparam int SWS_ST_CARRIER_BIT = 2;
    localparam int SWS_ST_SWITCH_N_BIT = 3;
    localparam int SWS_ST_JUMPER_BIT = 4;
    localparam int SWS_ST_SDA_BIT = 5;
    localparam int SWS_ST_UNLOCK_SEEN_BIT = 6;

    localparam logic [3:0] SWS_LATCH_RST = 4'h0;
    localparam logic [1:0] SWS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SWS_RESP_SLVERR = 2'h2;

    // timing
    localparam int unsigned SWS_CLK_HZ = 25000000;
    localparam int unsigned SWS_POR_MS = 30;
    localparam int unsigned SWS_HOLD_MS = 100;
    localparam int unsigned SWS_PERIOD_MS = 150;
    localparam int unsigned SWS_POR_CYC = SWS_POR_MS * (SWS_CLK_HZ / 1000);
    localparam int unsigned SWS_HOLD_CYC = SWS_HOLD_MS * (SWS_CLK_HZ / 1000);
    localparam int unsigned SWS_RUN_CYC = (SWS_PERIOD_MS - SWS_HOLD_MS) * (SWS_CLK_HZ / 1000);

    typedef enum logic [2:0] {
        SWS_ST_POR = 3'b001,
        SWS_ST_HOLD = 3'b010,
        SWS_ST_RUN = 3'b100
    } sws_state_e;

endpackage

// [hw/sws_supervisor.sv]
`timescale 1ns/1ps
module sws_supervisor
    import sws_pkg::*;
#(
    parameter int unsigned POR_CYCLES = SWS_POR_CYC,
    parameter int unsigned HOLD_CYCLES = SWS_HOLD_CYC,
    parameter int unsigned RUN_CYCLES = SWS_RUN_CYC,
    parameter int CNT_W = 24
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [4:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [4:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic supply_in_range_i,
    input wire logic watchdog_enable_jumper_i,
    input wire logic ext_reset_i,
    input wire logic tx_synth_locked_i,
    input wire logic rx_synth_locked_i,
    input wire logic carrier_detect_i,
    input wire logic output_disable_switch_n_i,
    input wire logic mem_sda_i,
    output logic supply_reset_n_o,
    output logic ctrl_reset_o,
    output logic mem_power_en_o,
    output logic mem_scl_o,
    output logic mem_sda_o,
    output logic mem_sda_oe_o,
    output logic synth_sclk_o,
    output logic synth_sdata_o,
    output logic tx_synth_load_n_o,
    output logic rx_synth_load_n_o,
    output logic transmit_key_n_o,
    output logic tx_on_indicator_o,
    output logic remote_power_monitor_o,
    output logic carrier_indicator_n_o,
    output logic receive_indicator_o,
    output logic fault_indicator_o,
    output logic fault_remote_o,
    output logic disable_indicator_o,
    output logic disable_remote_o,
    output logic tx_unlock_indicator_o,
    output logic rx_unlock_indicator_o
);

    // pin synchronisers
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= {mem_sda_i, output_disable_switch_n_i, carrier_detect_i,
                        rx_synth_locked_i, tx_synth_locked_i, ext_reset_i,
                        watchdog_enable_jumper_i, supply_in_range_i};
            sync2_r <= sync1_r;
        end
    end
    wire supply_ok_s = sync2_r[0];
    wire jumper_s = sync2_r[1];
    wire ext_rst_s = sync2_r[2];
    wire tx_lock_s = sync2_r[3];
    wire rx_lock_s = sync2_r[4];
    wire carrier_s = sync2_r[5];
    wire switch_n_s = sync2_r[6];
    wire sda_s = sync2_r[7];

    // register bus write side
    logic aw_have_r;
    logic w_have_r;
    logic [4:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    function automatic logic mapped(input logic [4:0] a);
        return a == SWS_SYNTH_LATCH_ADDR || a == SWS_XMIT_LATCH_ADDR ||
               a == SWS_MEM_IF_ADDR || a == SWS_SERVICE_ADDR || a == SWS_STATUS_ADDR;
    endfunction

    wire wr_go = aw_have_r && w_have_r && !bvalid_r;
    wire wr_en = wr_go && wstrb0_r;
    wire wr_syn = wr_en && awaddr_r == SWS_SYNTH_LATCH_ADDR;
    wire wr_xm = wr_en && awaddr_r == SWS_XMIT_LATCH_ADDR;
    wire wr_mem = wr_en && awaddr_r == SWS_MEM_IF_ADDR;
    wire wr_st = wr_en && awaddr_r == SWS_STATUS_ADDR;
    // a write to the service address is the controller's watchdog pulse
    wire service = wr_en && awaddr_r == SWS_SERVICE_ADDR;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 5'h00;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= SWS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_have_r) begin
                aw_have_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr_i[4:2], 2'b00};
            end
            if (s_axi_wvalid_i && !w_have_r) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb0_r <= s_axi_wstrb_i[0];
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(awaddr_r) ? SWS_RESP_OKAY : SWS_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // watchdog and supply sequencer
    sws_state_e state_r;
    sws_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire [CNT_W-1:0] cnt_inc = cnt_r + CNT_W'(1);
    wire por_done = cnt_r == CNT_W'(POR_CYCLES - 1);
    wire hold_done = cnt_r == CNT_W'(HOLD_CYCLES - 1);
    wire run_done = cnt_r == CNT_W'(RUN_CYCLES - 1);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_inc;
        if (!supply_ok_s) begin
            state_nxt = SWS_ST_POR;
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                SWS_ST_POR: begin
                    if (por_done) begin
                        state_nxt = SWS_ST_HOLD;
                        cnt_nxt = '0;
                    end
                end
                SWS_ST_HOLD: begin
                    if (ext_rst_s) begin
                        cnt_nxt = '0;
                    end else if (hold_done) begin
                        state_nxt = SWS_ST_RUN;
                        cnt_nxt = '0;
                    end
                end
                SWS_ST_RUN: begin
                    if (ext_rst_s) begin
                        state_nxt = SWS_ST_HOLD;
                        cnt_nxt = '0;
                    end else if (service || !jumper_s) begin
                        cnt_nxt = '0;
                    end else if (run_done) begin
                        state_nxt = SWS_ST_HOLD;
                        cnt_nxt = '0;
                    end
                end
                default: begin
                    state_nxt = SWS_ST_POR;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    wire reset_nxt = state_nxt != SWS_ST_RUN;
    logic supply_rst_n_r;
    logic ctrl_reset_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= SWS_ST_POR;
            cnt_r <= '0;
            supply_rst_n_r <= 1'b0;
            ctrl_reset_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            supply_rst_n_r <= state_nxt != SWS_ST_POR;
            ctrl_reset_r <= reset_nxt;
        end
    end

    // controller output latches, cleared while the controller is in reset
    logic [3:0] syn_latch_r;
    logic [1:0] xm_latch_r;
    logic [1:0] mem_latch_r;
    logic unlock_seen_r;
    wire any_unlock = !tx_lock_s || !rx_lock_s;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            syn_latch_r <= SWS_LATCH_RST;
            xm_latch_r <= SWS_LATCH_RST[1:0];
            mem_latch_r <= SWS_LATCH_RST[1:0];
            unlock_seen_r <= 1'b0;
        end else begin
            if (ctrl_reset_r) begin
                syn_latch_r <= SWS_LATCH_RST;
                xm_latch_r <= SWS_LATCH_RST[1:0];
                mem_latch_r <= SWS_LATCH_RST[1:0];
            end else begin
                if (wr_syn) syn_latch_r <= wdata_r[3:0];
                if (wr_xm) xm_latch_r <= wdata_r[1:0];
                if (wr_mem) mem_latch_r <= wdata_r[1:0];
            end
            // set beats a simultaneous write-one clear
            if (any_unlock) begin
                unlock_seen_r <= 1'b1;
            end else if (wr_st && wdata_r[SWS_ST_UNLOCK_SEEN_BIT]) begin
                unlock_seen_r <= 1'b0;
            end
        end
    end

    // read side
    wire [31:0] status_word = 32'({unlock_seen_r, sda_s, jumper_s, switch_n_s,
                                   carrier_s, rx_lock_s, tx_lock_s});
    logic [31:0] rd_mux;
    always_comb begin
        unique case ({s_axi_araddr_i[4:2], 2'b00})
            SWS_SYNTH_LATCH_ADDR: rd_mux = 32'(syn_latch_r);
            SWS_XMIT_LATCH_ADDR: rd_mux = 32'(xm_latch_r);
            SWS_MEM_IF_ADDR: rd_mux = 32'(mem_latch_r);
            SWS_STATUS_ADDR: rd_mux = status_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    wire ar_ok = mapped({s_axi_araddr_i[4:2], 2'b00});

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= SWS_RESP_OKAY;
        end else begin
            arready_r <= !rvalid_r && s_axi_arvalid_i && !arready_r;
            if (arready_r && s_axi_arvalid_i) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= ar_ok ? SWS_RESP_OKAY : SWS_RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready_i) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // transmit gating: request, both locks, disable switch not asserted (switch_n_s high), not in reset
    wire key_nxt = xm_latch_r[SWS_XM_KEY_BIT] && tx_lock_s && rx_lock_s
                   && switch_n_s && !ctrl_reset_r;
    logic key_r;
    logic [1:0] unlock_r;
    logic disable_r;
    logic carrier_r;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_r <= 1'b0;
            unlock_r <= 2'b00;
            disable_r <= 1'b0;
            carrier_r <= 1'b0;
        end else begin
            key_r <= key_nxt;
            unlock_r <= {!rx_lock_s, !tx_lock_s};
            disable_r <= !switch_n_s;
            carrier_r <= xm_latch_r[SWS_XM_CARRIER_BIT];
        end
    end

    assign s_axi_awready_o = !aw_have_r;
    assign s_axi_wready_o = !w_have_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign supply_reset_n_o = supply_rst_n_r;
    assign ctrl_reset_o = ctrl_reset_r;
    assign mem_power_en_o = !ctrl_reset_r;
    assign mem_scl_o = mem_latch_r[SWS_MEM_SCL_BIT];
    assign mem_sda_o = 1'b0;
    assign mem_sda_oe_o = mem_latch_r[SWS_MEM_SDA_LOW_BIT];
    assign synth_sclk_o = syn_latch_r[SWS_SYN_SCLK_BIT];
    assign synth_sdata_o = syn_latch_r[SWS_SYN_SDATA_BIT];
    assign tx_synth_load_n_o = syn_latch_r[SWS_SYN_TX_LOAD_N_BIT];
    assign rx_synth_load_n_o = syn_latch_r[SWS_SYN_RX_LOAD_N_BIT];
    assign transmit_key_n_o = !key_r;
    assign tx_on_indicator_o = key_r;
    assign remote_power_monitor_o = key_r;
    assign carrier_indicator_n_o = !carrier_r;
    assign receive_indicator_o = carrier_r;
    assign fault_indicator_o = ctrl_reset_r;
    assign fault_remote_o = ctrl_reset_r;
    assign disable_indicator_o = disable_r;
    assign disable_remote_o = disable_r;
    assign tx_unlock_indicator_o = unlock_r[0];
    assign rx_unlock_indicator_o = unlock_r[1];

    property p_mem_off;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        ctrl_reset_o |-> !mem_power_en_o && fault_indicator_o && fault_remote_o;
    endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory powered in reset");

    property p_timeout;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (state_r == SWS_ST_RUN && run_done && supply_ok_s && !ext_rst_s && jumper_s && !service)
        |=> state_r == SWS_ST_HOLD && ctrl_reset_o && cnt_r == '0;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not reset");

    property p_por_len;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(supply_reset_n_o) |-> $past(cnt_r) == CNT_W'(POR_CYCLES - 1);
    endproperty
    a_por_len: assert property (p_por_len) else $error("supply reset length wrong");

    property p_supply_forces;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !supply_ok_s |=> !supply_reset_n_o && ctrl_reset_o;
    endproperty
    a_supply_forces: assert property (p_supply_forces) else $error("dropout not reset");

    property p_hold_end;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(ctrl_reset_o) |-> $past(cnt_r) == CNT_W'(HOLD_CYCLES - 1) && supply_reset_n_o;
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold length wrong");

    property p_no_jumper;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (!jumper_s && state_r == SWS_ST_RUN && supply_ok_s && !ext_rst_s) |=> !ctrl_reset_o;
    endproperty
    a_no_jumper: assert property (p_no_jumper) else $error("reset without jumper");

    property p_key_gate;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !transmit_key_n_o |-> $past(tx_lock_s) && $past(rx_lock_s) && $past(switch_n_s)
                              && tx_on_indicator_o && remote_power_monitor_o;
    endproperty
    a_key_gate: assert property (p_key_gate) else $error("key while unsafe");

    property p_ext_reset;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        ext_rst_s ##1 ext_rst_s |=> ctrl_reset_o;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("external reset ignored");

    property p_latch_clear;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        // carrier indicator trails the cleared latch by one more flop
        ctrl_reset_o ##1 ctrl_reset_o ##1 ctrl_reset_o
        |-> syn_latch_r == SWS_LATCH_RST && carrier_indicator_n_o;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

endmodule // sws_supervisor

// [tb/sws_far_end.sv]
`timescale 1ns/1ps
module sws_far_end (
    input wire logic clk_i,
    input wire logic mem_sda_i,
    input wire logic mem_sda_oe_i,
    output logic sda_wire_o,
    input wire logic synth_sclk_i,
    input wire logic synth_sdata_i,
    input wire logic tx_load_n_i,
    input wire logic rx_load_n_i,
    output logic [7:0] tx_word_o,
    output logic [7:0] rx_word_o
);
    logic [7:0] shift_r = 8'h00;
    logic sclk_q = 1'b0;
    logic tx_q = 1'b1;
    logic rx_q = 1'b1;
    initial tx_word_o = 8'h00;
    initial rx_word_o = 8'h00;
    // memory stays released, so only the pull-up or the block's low drive sets the line
    assign sda_wire_o = (mem_sda_oe_i && !mem_sda_i) ? 1'b0 : 1'b1;
    always @(posedge clk_i) begin
        sclk_q <= synth_sclk_i;
        tx_q <= tx_load_n_i;
        rx_q <= rx_load_n_i;
        if (synth_sclk_i && !sclk_q) begin
            shift_r <= {shift_r[6:0], synth_sdata_i};
        end
        // word is taken on the falling edge of each board's low-active load
        if (!tx_load_n_i && tx_q) begin
            tx_word_o <= shift_r;
        end
        if (!rx_load_n_i && rx_q) begin
            rx_word_o <= shift_r;
        end
    end
endmodule // sws_far_end

// [tb/test_translator_supervisor_watchdog.sv]
`timescale 1ns/1ps
module test_translator_supervisor_watchdog;
    import sws_pkg::*;
    localparam int unsigned POR = 20;
    localparam int unsigned HOLD = 40;
    localparam int unsigned RUN = 30;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic supply = 1'b1, jumper = 1'b0, ext_rst = 1'b0, tx_lk = 1'b1, rx_lk = 1'b1;
    logic cd = 1'b0, sw_n = 1'b1;
    wire awready, wready, bvalid, arready, rvalid, sda, sup_n, ctrl_rst, mem_pwr, scl, sda_d;
    wire sda_oe, sclk, sdat, tx_ld_n, rx_ld_n, key_n, tx_on, pwr_mon, car_n, receive_indicator, fault;
    wire fault_rem, dis, dis_rem, tx_unl, rx_unl;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] tx_word, rx_word;
    wire [1:0] mon = {sup_n, ctrl_rst};
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    logic [1:0] resp;
    logic [31:0] rd;

    sws_supervisor #(.POR_CYCLES(POR), .HOLD_CYCLES(HOLD), .RUN_CYCLES(RUN), .CNT_W(24))
    sws_supervisor_i (
        .ref_clk_i(clk), .rstn_i(rstn),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .supply_in_range_i(supply), .watchdog_enable_jumper_i(jumper), .ext_reset_i(ext_rst),
        .tx_synth_locked_i(tx_lk), .rx_synth_locked_i(rx_lk), .carrier_detect_i(cd),
        .output_disable_switch_n_i(sw_n), .mem_sda_i(sda), .supply_reset_n_o(sup_n),
        .ctrl_reset_o(ctrl_rst), .mem_power_en_o(mem_pwr), .mem_scl_o(scl), .mem_sda_o(sda_d),
        .mem_sda_oe_o(sda_oe), .synth_sclk_o(sclk), .synth_sdata_o(sdat),
        .tx_synth_load_n_o(tx_ld_n), .rx_synth_load_n_o(rx_ld_n), .transmit_key_n_o(key_n),
        .tx_on_indicator_o(tx_on), .remote_power_monitor_o(pwr_mon),
        .carrier_indicator_n_o(car_n), .receive_indicator_o(receive_indicator), .fault_indicator_o(fault),
        .fault_remote_o(fault_rem), .disable_indicator_o(dis), .disable_remote_o(dis_rem),
        .tx_unlock_indicator_o(tx_unl), .rx_unlock_indicator_o(rx_unl)
    );

    sws_far_end sws_far_end_i (
        .clk_i(clk), .mem_sda_i(sda_d), .mem_sda_oe_i(sda_oe), .sda_wire_o(sda),
        .synth_sclk_i(sclk), .synth_sdata_i(sdat), .tx_load_n_i(tx_ld_n),
        .rx_load_n_i(rx_ld_n), .tx_word_o(tx_word), .rx_word_o(rx_word)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake would otherwise stall the run for good
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wait_mon(input int idx, input logic v, output int k);
        k = 0;
        while (mon[idx] !== v && k < 5000) begin
            @(posedge clk);
            k = k + 1;
        end
    endtask

    // both channels offered together, each dropped at its own take
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    initial begin
        repeat (7) @(posedge clk);
        chk("rst ctrl", {ctrl_rst, sup_n, fault, fault_rem}, 32'hb);
        chk("rst outs", {mem_pwr, key_n, car_n, tx_on, receive_indicator}, 32'h0c);
        @(posedge clk);
        rstn <= 1'b1;
        wait_mon(1, 1'b1, n);
        chk("por len", (n >= POR && n <= POR + 4), 32'h1);
        chk("hold pwr", {ctrl_rst, mem_pwr, fault}, 32'h5);
        wait_mon(0, 1'b0, n);
        chk("hold len", (n >= HOLD && n <= HOLD + 3), 32'h1);
        wait_cyc(2);
        chk("run outs", {mem_pwr, fault, fault_rem}, 32'h4);
        wait_cyc(RUN + 20);
        chk("no jumper", ctrl_rst, 32'h0);
        axi_wr(SWS_XMIT_LATCH_ADDR, 32'h1, resp);
        wait_cyc(6);
        chk("keyed", {key_n, tx_on, pwr_mon}, 32'h3);
        tx_lk <= 1'b0;
        wait_cyc(6);
        chk("tx unlock", {key_n, tx_unl, rx_unl, tx_on}, 32'hc);
        axi_rd(SWS_STATUS_ADDR, rd, resp);
        chk("unlock seen", rd[6:0], 32'h6a);
        tx_lk <= 1'b1;
        rx_lk <= 1'b0;
        wait_cyc(6);
        chk("rx unlock", {key_n, tx_unl, rx_unl}, 32'h5);
        rx_lk <= 1'b1;
        wait_cyc(4);
        axi_wr(SWS_STATUS_ADDR, 32'h40, resp);
        axi_rd(SWS_STATUS_ADDR, rd, resp);
        chk("status", rd, 32'h2b);
        sw_n <= 1'b0;
        wait_cyc(6);
        chk("disabled", {dis, dis_rem, key_n}, 32'h7);
        sw_n <= 1'b1;
        wait_cyc(6);
        chk("enabled", {dis, key_n}, 32'h0);
        axi_wr(SWS_XMIT_LATCH_ADDR, 32'h3, resp);
        cd <= 1'b1;
        wait_cyc(6);
        chk("carrier", {car_n, receive_indicator}, 32'h1);
        axi_rd(SWS_STATUS_ADDR, rd, resp);
        chk("carrier st", rd[SWS_ST_CARRIER_BIT], 32'h1);
        axi_wr(SWS_MEM_IF_ADDR, 32'h2, resp);
        wait_cyc(4);
        chk("sda low", {sda_oe, sda, scl}, 32'h4);
        axi_rd(SWS_STATUS_ADDR, rd, resp);
        chk("sda st", rd[SWS_ST_SDA_BIT], 32'h0);
        axi_wr(SWS_MEM_IF_ADDR, 32'h1, resp);
        wait_cyc(4);
        chk("scl high", {sda_oe, sda, scl}, 32'h3);
        for (int i = 7; i >= 0; i--) begin
            axi_wr(SWS_SYNTH_LATCH_ADDR, {28'h0, 2'b11, ((8'ha5 >> i) & 8'h1) == 8'h1, 1'b0}, resp);
            axi_wr(SWS_SYNTH_LATCH_ADDR, {28'h0, 2'b11, ((8'ha5 >> i) & 8'h1) == 8'h1, 1'b1}, resp);
        end
        axi_wr(SWS_SYNTH_LATCH_ADDR, 32'h8, resp);
        wait_cyc(4);
        chk("tx load", {tx_ld_n, rx_ld_n, tx_word}, {22'h0, 2'b01, 8'ha5});
        axi_wr(SWS_SYNTH_LATCH_ADDR, 32'h4, resp);
        wait_cyc(4);
        chk("rx load", {tx_ld_n, rx_ld_n, rx_word}, {22'h0, 2'b10, 8'ha5});
        // low strobe byte off: the write must leave the key latch alone
        wstrb <= 4'he;
        axi_wr(SWS_XMIT_LATCH_ADDR, 32'h0, resp);
        wstrb <= 4'hf;
        wait_cyc(2);
        chk("strb off", {key_n, receive_indicator, resp}, {29'h0, 1'b1, SWS_RESP_OKAY});
        axi_wr(5'h14, 32'h1, resp);
        chk("bad wr", resp, SWS_RESP_SLVERR);
        axi_rd(5'h1c, rd, resp);
        chk("bad rd", {rd[29:0], resp}, {30'h0, SWS_RESP_SLVERR});
        jumper <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            axi_wr(SWS_SERVICE_ADDR, 32'h1, resp);
            wait_cyc(8);
        end
        chk("serviced", ctrl_rst, 32'h0);
        wait_mon(0, 1'b1, n);
        chk("timeout len", (n >= RUN - 12 && n <= RUN - 4), 32'h1);
        wait_cyc(3);
        chk("wd reset", {fault, mem_pwr, key_n, car_n, tx_on}, 32'h16);
        wait_mon(0, 1'b0, n);
        chk("rehold len", (n >= HOLD - 4 && n <= HOLD + 3), 32'h1);
        jumper <= 1'b0;
        ext_rst <= 1'b1;
        wait_mon(0, 1'b1, n);
        chk("ext rst", n <= 6, 32'h1);
        wait_cyc(HOLD + 10);
        chk("ext held", ctrl_rst, 32'h1);
        ext_rst <= 1'b0;
        wait_mon(0, 1'b0, n);
        chk("ext hold len", (n >= HOLD && n <= HOLD + 5), 32'h1);
        supply <= 1'b0;
        wait_mon(1, 1'b0, n);
        chk("drop", n <= 6, 32'h1);
        wait_cyc(3);
        chk("drop rst", {ctrl_rst, fault}, 32'h3);
        wait_cyc(POR + 10);
        chk("drop held", {sup_n, ctrl_rst}, 32'h1);
        supply <= 1'b1;
        wait_mon(1, 1'b1, n);
        chk("repor len", (n >= POR && n <= POR + 5), 32'h1);
        end_sim();
    end
endmodule // test_translator_supervisor_watchdog
